// ==== hw/flash_nv_interface_config.sv ====
// What this block does
// RULE_01 - Bit 7 default enables data line three as reset when deselected or not quad.
// RULE_02 - Ships with line-three reset default cleared; resets load it from that bit.
// RULE_03 - Bits 6:5 give drive strength at every reset; 00 strongest, 11 factory.
// RULE_04 - Bit 3 default starts the device in quad instruction or legacy serial mode.
// RULE_05 - In quad instruction mode every transfer, opcode included, is four bits wide.
// RULE_06 - Host enters quad mode with enter command, leaves with exit command, or writes.
// RULE_07 - Volatile protocol switch takes effect at once; next command uses new width.
// RULE_08 - Host polls busy after programming the non-volatile protocol bit.
// RULE_09 - Bit 2 default selects protection scheme; 0 legacy range, 1 block locking.
// RULE_10 - Bit 1 default selects address length; 1 four bytes, 0 three bytes.
// RULE_11 - Variable-length address commands take 32 address bits in 4-byte mode.
// RULE_12 - Bits 4 and 0 are reserved, read zero and ignore writes.
// RULE_13 - Host sends write enable before writes and reads with any-register read.
// RULE_14 - Updating the address length default also updates current address length.
// RULE_15 - While the register lock bit is set every write here is refused.
// RULE_16 - Every reset copies the defaults into the volatile controls before commands.
`timescale 1ns/10ps
module flash_nv_interface_config
    import flash_nv_pkg::*;
#(
    parameter int PROG_CYCLES = PROGRAM_CYCLES
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic [3:0] io_in,
    output logic [3:0] io_out,
    output logic [3:0] io_oe_n_out,
    input wire logic hw_reset_n_in,
    input wire logic sw_reset_in,
    input wire logic register_lock_bit_in,
    input wire logic quad_data_width_in,
    output logic line3_reset_enable_out,
    output logic [1:0] drive_strength_out,
    output logic quad_instruction_out,
    output logic protect_scheme_out,
    output logic current_address_length_out,
    output logic [7:0] interface_defaults_nonvolatile_out,
    output logic nv_busy_out,
    output logic ready_out,
    output logic reset_request_out
);

    // ---------------- Core clock domain ----------------
    localparam int NSYNC = 4;
    localparam int SY_HWRST = 0;
    localparam int SY_IO3 = 1;
    localparam int SY_CS = 2;
    localparam int SY_REQ = 3;

    logic [NSYNC-1:0] sync_raw;
    logic [NSYNC-1:0] sync_level;
    logic req_tog_reg;
    write_req_s req_hold_reg;
    logic [7:0] nv_data;
    logic nv_busy;
    logic nv_prog_valid;
    logic [7:0] nv_prog_data;
    logic [7:0] controls_reg;
    logic ready_reg;
    logic req_seen_reg;
    logic req_event;
    logic write_ok;
    logic line3_reset;
    logic reset_event;
    link_view_s view;
    link_view_s pub_reg;
    logic pub_tog_reg;

    assign sync_raw = {req_tog_reg, cs_n_in, io_in[3], hw_reset_n_in};

    // Three-stage synchronisers; a level is taken once the second and third stage agree
    generate
        for (genvar i = 0; i < NSYNC; i++) begin : g_sync
            // Reset to each input's idle level so no false edge follows reset
            localparam logic IDLE = (i == SY_REQ) ? 1'b0 : 1'b1;
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic lvl_reg;
            always_ff @(posedge clk_in) begin
                if (sys_rst_in) begin
                    s1_reg <= IDLE;
                    s2_reg <= IDLE;
                    s3_reg <= IDLE;
                    lvl_reg <= IDLE;
                end else begin
                    s1_reg <= sync_raw[i];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    if (s2_reg == s3_reg) begin
                        lvl_reg <= s3_reg;
                    end
                end
            end
            assign sync_level[i] = lvl_reg;
        end
    endgenerate

    // Line three acts as reset only while deselected or with quad width off [RULE_01]
    assign line3_reset = controls_reg[BIT_LINE3_RESET] & ~sync_level[SY_IO3]
        & (sync_level[SY_CS] | ~(quad_data_width_in | controls_reg[BIT_QUAD_INSTRUCTION]));
    assign reset_event = ~sync_level[SY_HWRST] | line3_reset | sw_reset_in;
    assign reset_request_out = line3_reset;

    // Toggle from the link marks a new write; the held word is stable by then
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            req_seen_reg <= 1'b0;
        end else begin
            req_seen_reg <= sync_level[SY_REQ];
        end
    end
    assign req_event = sync_level[SY_REQ] != req_seen_reg;

    // Writes are dropped while locked, while programming or before the reset load [RULE_15]
    assign write_ok = req_event & ready_reg & ~register_lock_bit_in & ~nv_busy;
    assign nv_prog_valid = write_ok & req_hold_reg.to_nonvolatile;
    assign nv_prog_data = req_hold_reg.data & NV_WRITABLE_MASK; // [RULE_12]

    nv_byte_store #(
        .FACTORY(FACTORY_DEFAULTS), // [RULE_02] [RULE_03] [RULE_09]
        .PROG_CYCLES(PROG_CYCLES)
    ) u_store (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .prog_valid_in(nv_prog_valid),
        .prog_data_in(nv_prog_data),
        .data_out(nv_data),
        .busy_out(nv_busy)
    );

    // Volatile controls: loaded from the defaults after every reset, then steered by writes
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || reset_event) begin
            ready_reg <= 1'b0;
            controls_reg <= 8'h00;
        end else if (!ready_reg) begin
            ready_reg <= 1'b1; // Commands wait for this load [RULE_16]
            controls_reg <= nv_data & NV_WRITABLE_MASK; // [RULE_01] [RULE_03] [RULE_04] [RULE_09]
            controls_reg[BIT_ADDRESS_CURRENT] <= nv_data[BIT_ADDRESS_DEFAULT]; // [RULE_10]
        end else if (write_ok && !req_hold_reg.to_nonvolatile) begin
            controls_reg <= (req_hold_reg.data & VOL_WRITABLE_MASK) | (controls_reg & ~VOL_WRITABLE_MASK);
        end else if (nv_prog_valid) begin
            controls_reg[BIT_ADDRESS_CURRENT] <= nv_prog_data[BIT_ADDRESS_DEFAULT]; // [RULE_14]
        end
    end

    assign view.busy = nv_busy;
    assign view.locked = register_lock_bit_in;
    assign view.nonvolatile = nv_data;
    assign view.volatile_byte = {controls_reg[7:2], nv_data[BIT_ADDRESS_DEFAULT], controls_reg[BIT_ADDRESS_CURRENT]};

    // Publish a fresh view to the link; changes are rare so one held word is enough
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pub_reg <= '0;
            pub_tog_reg <= 1'b0;
        end else if (view != pub_reg) begin
            pub_reg <= view;
            pub_tog_reg <= ~pub_tog_reg;
        end
    end

    assign line3_reset_enable_out = controls_reg[BIT_LINE3_RESET];
    assign drive_strength_out = controls_reg[BIT_DRIVE_HI:BIT_DRIVE_LO];
    assign quad_instruction_out = controls_reg[BIT_QUAD_INSTRUCTION];
    assign protect_scheme_out = controls_reg[BIT_PROTECT_SCHEME];
    assign current_address_length_out = controls_reg[BIT_ADDRESS_CURRENT];
    assign interface_defaults_nonvolatile_out = nv_data;
    assign nv_busy_out = nv_busy;
    assign ready_out = ready_reg;

    // ---------------- Link clock domain ----------------
    link_state_e state_reg;
    logic [2:0] cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] opcode_reg;
    logic [2:0] byte_idx_reg;
    logic [31:0] addr_reg;
    logic [7:0] out_reg;
    logic [2:0] pub_sync_reg;
    logic pub_seen_reg;
    link_view_s mirror_reg;
    logic [7:0] local_v_reg;
    logic wel_reg;
    logic quad_mode;
    logic [3:0] step;
    logic [3:0] cnt_sum;
    logic byte_done;
    logic [7:0] byte_in;
    logic [2:0] addr_bytes;
    logic [31:0] addr_full;
    logic wr_allowed;
    logic wr_fire;
    write_req_s wr_next;

    // Opcode width follows the local protocol bit [RULE_05]
    assign quad_mode = local_v_reg[BIT_QUAD_INSTRUCTION];
    assign step = quad_mode ? STEP_QUAD : STEP_SINGLE;
    assign cnt_sum = {1'b0, cnt_reg} + step;
    assign byte_done = cnt_sum == BYTE_BITS;
    assign byte_in = quad_mode ? {shift_reg[3:0], io_in} : {shift_reg[6:0], io_in[0]};
    // Variable address length follows the current address bit [RULE_11]
    assign addr_bytes = local_v_reg[BIT_ADDRESS_CURRENT] ? ADDR_BYTES_LONG : ADDR_BYTES_SHORT;
    assign addr_full = {addr_reg[23:0], byte_in};
    assign wr_allowed = wel_reg & ~mirror_reg.locked & ~mirror_reg.busy; // [RULE_15]

    // Decide whether this edge completes a register write and what it carries
    always_comb begin
        wr_fire = 1'b0;
        wr_next = '0;
        if (byte_done && state_reg == ST_OPCODE && byte_in == OP_ENTER_QUAD_INSTRUCTION) begin
            wr_fire = ~mirror_reg.locked;
            wr_next.data = local_v_reg | (8'h01 << BIT_QUAD_INSTRUCTION);
        end else if (byte_done && state_reg == ST_OPCODE && byte_in == OP_EXIT_QUAD_INSTRUCTION) begin
            wr_fire = ~mirror_reg.locked;
            wr_next.data = local_v_reg & ~(8'h01 << BIT_QUAD_INSTRUCTION);
        end else if (byte_done && state_reg == ST_WRITE_DATA && wr_allowed) begin
            if (opcode_reg == OP_REGISTER_WRITE) begin
                wr_fire = byte_idx_reg == REGISTER_WRITE_CR2_INDEX;
                wr_next.to_nonvolatile = 1'b1;
            end else begin
                wr_fire = (addr_reg == ADDR_DEFAULTS_NONVOLATILE) | (addr_reg == ADDR_CONTROLS_VOLATILE);
                wr_next.to_nonvolatile = addr_reg == ADDR_DEFAULTS_NONVOLATILE;
            end
            wr_next.data = byte_in;
        end
    end

    // Frame decoder; deselecting the device clears all frame state
    always_ff @(posedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            state_reg <= ST_OPCODE;
            cnt_reg <= 3'd0;
            shift_reg <= 8'h00;
            opcode_reg <= 8'h00;
            byte_idx_reg <= 3'd0;
            addr_reg <= 32'h0000_0000;
            out_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_sum[2:0];
            shift_reg <= byte_in;
            case (state_reg)
                ST_OPCODE: begin
                    if (byte_done) begin
                        opcode_reg <= byte_in;
                        byte_idx_reg <= 3'd0;
                        if (byte_in == OP_ANY_REGISTER_READ || byte_in == OP_ANY_REGISTER_WRITE) begin
                            state_reg <= ST_ADDRESS;
                        end else if (byte_in == OP_REGISTER_WRITE) begin
                            state_reg <= ST_WRITE_DATA;
                        end else begin
                            state_reg <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDRESS: begin
                    if (byte_done) begin
                        addr_reg <= addr_full;
                        byte_idx_reg <= byte_idx_reg + 3'd1;
                        if (byte_idx_reg + 3'd1 == addr_bytes) begin // [RULE_11]
                            byte_idx_reg <= 3'd0;
                            if (opcode_reg == OP_ANY_REGISTER_READ) begin
                                state_reg <= ST_READ_DATA;
                                if (addr_full == ADDR_DEFAULTS_NONVOLATILE) begin
                                    out_reg <= mirror_reg.nonvolatile & NV_WRITABLE_MASK; // [RULE_12]
                                end else if (addr_full == ADDR_CONTROLS_VOLATILE) begin
                                    out_reg <= local_v_reg;
                                end else begin
                                    out_reg <= 8'h00;
                                end
                            end else begin
                                state_reg <= ST_WRITE_DATA;
                            end
                        end
                    end
                end
                ST_WRITE_DATA: begin
                    if (byte_done && byte_idx_reg != 3'd7) begin
                        byte_idx_reg <= byte_idx_reg + 3'd1;
                    end
                end
                ST_READ_DATA: begin
                    // Same byte repeats while the host keeps clocking
                    if (quad_mode) begin
                        out_reg <= {out_reg[3:0], out_reg[7:4]};
                    end else begin
                        out_reg <= {out_reg[6:0], out_reg[7]};
                    end
                end
                ST_IGNORE: begin
                    state_reg <= ST_IGNORE;
                end
                default: begin
                    state_reg <= ST_IGNORE;
                end
            endcase
        end
    end

    // Read data: single mode drives the serial output line, quad mode all four lines [RULE_05]
    assign io_out = quad_mode ? out_reg[7:4] : {2'b00, out_reg[7], 1'b0};
    assign io_oe_n_out = (state_reg != ST_READ_DATA) ? 4'hf : (quad_mode ? 4'h0 : 4'hd);

    // Link-side state that outlives a frame: mirror, local controls, write enable, request toggle
    always_ff @(posedge sck_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            pub_sync_reg <= 3'b000;
            pub_seen_reg <= 1'b0;
            mirror_reg <= '0;
            local_v_reg <= 8'h00;
            wel_reg <= 1'b0;
            req_tog_reg <= 1'b0;
            req_hold_reg <= '0;
        end else begin
            pub_sync_reg <= {pub_sync_reg[1:0], pub_tog_reg};
            // Toggle parity alone can miss two quick changes, so a differing word is taken too
            if (pub_sync_reg[2] == pub_sync_reg[1] && pub_sync_reg[1] == pub_sync_reg[0]
                && (pub_sync_reg[2] != pub_seen_reg || pub_reg != mirror_reg)) begin
                pub_seen_reg <= pub_sync_reg[2];
                mirror_reg <= pub_reg;
                local_v_reg <= pub_reg.volatile_byte;
            end
            if (!cs_n_in && state_reg == ST_OPCODE && byte_done && byte_in == OP_NONVOLATILE_WRITE_ENABLE) begin
                wel_reg <= 1'b1; // [RULE_13]
            end else if (!cs_n_in && state_reg == ST_WRITE_DATA && byte_done
                && (opcode_reg != OP_REGISTER_WRITE || byte_idx_reg == REGISTER_WRITE_CR2_INDEX)) begin
                wel_reg <= 1'b0;
            end
            if (!cs_n_in && wr_fire) begin
                req_hold_reg <= wr_next;
                req_tog_reg <= ~req_tog_reg;
                // Protocol changes take hold on the very next edge [RULE_06] [RULE_07]
                if (!wr_next.to_nonvolatile) begin
                    local_v_reg <= (wr_next.data & VOL_WRITABLE_MASK) | (local_v_reg & ~VOL_WRITABLE_MASK);
                end else begin
                    // Busy shows at once so the link refuses further writes [RULE_08] [RULE_14]
                    mirror_reg.busy <= 1'b1;
                    local_v_reg[BIT_ADDRESS_CURRENT] <= wr_next.data[BIT_ADDRESS_DEFAULT];
                end
            end
        end
    end

endmodule

// ==== hw/flash_nv_pkg.sv ====
package flash_nv_pkg;

    // Commands understood on the link
    localparam logic [7:0] OP_NONVOLATILE_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_REGISTER_WRITE = 8'h01;
    localparam logic [7:0] OP_ANY_REGISTER_READ = 8'h65;
    localparam logic [7:0] OP_ANY_REGISTER_WRITE = 8'h71;
    localparam logic [7:0] OP_ENTER_QUAD_INSTRUCTION = 8'h38;
    localparam logic [7:0] OP_EXIT_QUAD_INSTRUCTION = 8'hf5;

    // Register addresses seen by the any-register commands
    localparam logic [31:0] ADDR_DEFAULTS_NONVOLATILE = 32'h0000_0003;
    localparam logic [31:0] ADDR_CONTROLS_VOLATILE = 32'h0080_0003;

    // Field positions, shared by the non-volatile and volatile bytes
    localparam int BIT_LINE3_RESET = 7;
    localparam int BIT_DRIVE_HI = 6;
    localparam int BIT_DRIVE_LO = 5;
    localparam int BIT_QUAD_INSTRUCTION = 3;
    localparam int BIT_PROTECT_SCHEME = 2;
    localparam int BIT_ADDRESS_DEFAULT = 1;
    localparam int BIT_ADDRESS_CURRENT = 0;

    // Factory content: line-3 reset off, weakest drive, legacy protocol and protection, 3-byte address
    localparam logic [7:0] FACTORY_DEFAULTS = 8'h60;
    localparam logic [7:0] NV_WRITABLE_MASK = 8'hee;
    localparam logic [7:0] VOL_WRITABLE_MASK = 8'hed;
    localparam logic [2:0] REGISTER_WRITE_CR2_INDEX = 3'd2;

    // Link bit stepping
    localparam logic [3:0] STEP_SINGLE = 4'd1;
    localparam logic [3:0] STEP_QUAD = 4'd4;
    localparam logic [3:0] BYTE_BITS = 4'd8;
    localparam logic [2:0] ADDR_BYTES_SHORT = 3'd3;
    localparam logic [2:0] ADDR_BYTES_LONG = 3'd4;

    // Timing
    localparam int CLK_MHZ = 50;
    localparam int PROGRAM_TIME_NS = 200000;
    localparam int PROGRAM_CYCLES = PROGRAM_TIME_NS * CLK_MHZ / 1000;

    typedef enum logic [2:0] {
        ST_OPCODE = 3'b000,
        ST_ADDRESS = 3'b001,
        ST_WRITE_DATA = 3'b010,
        ST_READ_DATA = 3'b011,
        ST_IGNORE = 3'b100
    } link_state_e;

    // Write handed from the link domain to the core domain
    typedef struct packed {
        logic to_nonvolatile;
        logic [7:0] data;
    } write_req_s;

    // Register state mirrored from the core domain into the link domain
    typedef struct packed {
        logic busy;
        logic locked;
        logic [7:0] nonvolatile;
        logic [7:0] volatile_byte;
    } link_view_s;

endpackage

// ==== hw/nv_byte_store.sv ====
`timescale 1ns/10ps
module nv_byte_store
    import flash_nv_pkg::*;
#(
    parameter logic [7:0] FACTORY = FACTORY_DEFAULTS,
    parameter int PROG_CYCLES = PROGRAM_CYCLES
) (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic prog_valid_in,
    input wire logic [7:0] prog_data_in,
    output logic [7:0] data_out,
    output logic busy_out
);

    logic [7:0] cell_reg;
    logic [7:0] pending_reg;
    logic [15:0] timer_reg;
    logic busy_reg;

    // Power-up stands in for factory content; a new value lands only when the program time ends
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cell_reg <= FACTORY;
            pending_reg <= 8'h00;
            busy_reg <= 1'b0;
            timer_reg <= 16'h0000;
        end else if (!busy_reg && prog_valid_in) begin
            pending_reg <= prog_data_in;
            busy_reg <= 1'b1;
            timer_reg <= 16'(PROG_CYCLES - 1);
        end else if (busy_reg) begin
            if (timer_reg == 16'h0000) begin
                cell_reg <= pending_reg;
                busy_reg <= 1'b0;
            end else begin
                timer_reg <= timer_reg - 16'h0001;
            end
        end
    end

    assign data_out = cell_reg;
    assign busy_out = busy_reg;

endmodule

// ==== tb/flash_host_model.sv ====
`timescale 1ns/10ps
module flash_host_model (
    output logic sck_out,
    output logic cs_n_out,
    output logic [3:0] wire_out,
    input wire logic [3:0] dev_io_in,
    input wire logic [3:0] dev_oe_n_in
);
    logic [3:0] drv_reg = 4'h8;
    // Line level: the device wins where it drives, else the host
    assign wire_out = (dev_oe_n_in & drv_reg) | (~dev_oe_n_in & dev_io_in);
    // Serial clock stands low outside frames
    initial begin
        sck_out = 1'b0;
        cs_n_out = 1'b1;
    end
    // One byte MSB first; lines change only while sck is low
    task automatic xfer(input logic [7:0] b, input bit quad, output logic [7:0] r);
        for (int k = 0; k < (quad ? 2 : 8); k++) begin
            if (quad)
                drv_reg = b[7 - 4 * k -: 4];
            else
                drv_reg = {1'b1, ~drv_reg[2:1], b[7 - k]};
            #3;
            r = quad ? {r[3:0], wire_out} : {r[6:0], wire_out[1]};
            sck_out = 1'b1;
            #3;
            sck_out = 1'b0;
        end
    endtask
    // Idle lines toggle so a stale value never looks valid; line 3 stays high except while quad bytes carry data on it
    task automatic frame(input logic [7:0] q[$], input bit quad, output logic [7:0] r);
        cs_n_out = 1'b0;
        foreach (q[i]) xfer(q[i], quad, r);
        #3;
        cs_n_out = 1'b1;
        drv_reg = {1'b1, ~drv_reg[2:0]};
        #200; // Ten core cycles let a write cross before the next frame
    endtask
    task automatic set_line3(input logic v);
        drv_reg[3] = v;
    endtask
endmodule

// ==== tb/flash_nv_props.sv ====
`timescale 1ns/10ps
module flash_nv_props (
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] io_in,
    input wire logic [3:0] io_oe_n_out,
    input wire logic sw_reset_in,
    input wire logic register_lock_bit_in,
    input wire logic line3_reset_enable_out,
    input wire logic [1:0] drive_strength_out,
    input wire logic quad_instruction_out,
    input wire logic protect_scheme_out,
    input wire logic current_address_length_out,
    input wire logic [7:0] interface_defaults_nonvolatile_out,
    input wire logic nv_busy_out,
    input wire logic ready_out,
    input wire logic reset_request_out
);
    logic [7:0] nv;
    // Short alias for the stored byte
    assign nv = interface_defaults_nonvolatile_out;
    // One clock domain, so one clocking and one disable serve all checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    property p_boot; $fell(sys_rst_in) |-> ##[1:3] ready_out; endproperty
    a_boot: assert property (p_boot) else $error("ready missing after reset");
    property p_soft; sw_reset_in |=> !ready_out; endproperty
    a_soft: assert property (p_soft) else $error("ready held through soft reset");
    property p_load; $rose(ready_out) |-> drive_strength_out == nv[6:5] && line3_reset_enable_out == nv[7]
        && quad_instruction_out == nv[3] && protect_scheme_out == nv[2] && current_address_length_out == nv[1];
    endproperty
    a_load: assert property (p_load) else $error("controls differ from defaults");
    property p_reserved; nv[4] == 1'b0 && nv[0] == 1'b0; endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");
    property p_lock; register_lock_bit_in && $past(register_lock_bit_in, 8) |-> !$rose(nv_busy_out); endproperty
    a_lock: assert property (p_lock) else $error("write accepted while locked");
    property p_addr; $fell(nv_busy_out) |-> current_address_length_out == nv[1]; endproperty
    a_addr: assert property (p_addr) else $error("address length not following default");
    property p_line3; reset_request_out |-> line3_reset_enable_out
        && (!$past(io_in[3], 4) || !$past(io_in[3], 5)); endproperty
    a_line3: assert property (p_line3) else $error("reset request without cause");
    property p_quad_oe; io_oe_n_out == 4'h0 |-> quad_instruction_out; endproperty
    a_quad_oe: assert property (p_quad_oe) else $error("four lines driven outside quad");
endmodule
bind flash_nv_interface_config flash_nv_props props_u (.*);

// ==== tb/tb.sv ====
`timescale 1ns/10ps
module tb;
    import flash_nv_pkg::*;
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic sw_reset_in = 1'b0;
    logic hw_reset_n_in = 1'b1;
    logic register_lock_bit_in = 1'b0;
    logic quad_data_width_in = 1'b0;
    logic sck_in, cs_n_in, nv_busy_out, ready_out, reset_request_out, line3_reset_enable_out;
    logic quad_instruction_out, protect_scheme_out, current_address_length_out;
    logic [1:0] drive_strength_out;
    logic [3:0] io_in, io_out, io_oe_n_out;
    logic [7:0] interface_defaults_nonvolatile_out, rd, d;
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    bit quad = 0;
    bit a4 = 0;
    always #10 clk_in = ~clk_in;
    // Short program time keeps the run brief
    flash_nv_interface_config #(.PROG_CYCLES(20)) dut_u (.*);
    flash_host_model host_u (.sck_out(sck_in), .cs_n_out(cs_n_in), .wire_out(io_in), .dev_io_in(io_out),
        .dev_oe_n_in(io_oe_n_out));
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks=%0d fails=%0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Volatile view expected from a stored byte
    function automatic logic [7:0] ctl(input logic [7:0] n);
        return {n[7], n[6:5], 1'b0, n[3:2], 1'b0, n[1]};
    endfunction
    task automatic chk_ctl(input logic [7:0] n);
        check({line3_reset_enable_out, drive_strength_out, 1'b0, quad_instruction_out, protect_scheme_out, 1'b0,
            current_address_length_out}, ctl(n));
    endtask
    // Opcode, address of the stored byte in the current length, one data byte
    task automatic cmd(input logic [7:0] op, input logic [7:0] dt);
        logic [7:0] q[$];
        q = {op, 8'h00, 8'h00, 8'h03, dt};
        if (a4)
            q.insert(1, 8'h00);
        host_u.frame(q, quad, rd);
    endtask
    task automatic nv_write(input logic [7:0] v);
        host_u.frame({OP_NONVOLATILE_WRITE_ENABLE}, quad, rd);
        cmd(OP_ANY_REGISTER_WRITE, v);
        for (int i = 0; i < 100 && nv_busy_out !== 1'b0; i++)
            @(negedge clk_in);
    endtask
    // Pulse a reset source, check the reload, then wake the link view
    task automatic pulse(input bit hw, input logic [7:0] n);
        @(negedge clk_in);
        hw_reset_n_in = !hw;
        sw_reset_in = !hw;
        repeat (4) @(negedge clk_in);
        hw_reset_n_in = 1'b1;
        sw_reset_in = 1'b0;
        repeat (8) @(negedge clk_in);
        quad = n[3];
        a4 = n[1];
        check({7'h0, ready_out}, 8'h01);
        chk_ctl(n);
        host_u.frame({8'h00, 8'h00}, quad, rd);
    endtask
    // Cut a hang short well past the expected run length
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        d = 8'($urandom(32'h7136));
        repeat (6) @(negedge clk_in);
        sys_rst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        check(interface_defaults_nonvolatile_out, 8'h60);
        chk_ctl(8'h60);
        host_u.frame({8'h00, 8'h00}, 1'b0, rd);
        cmd(OP_ANY_REGISTER_WRITE, 8'hff);
        repeat (30) @(negedge clk_in);
        cmd(OP_ANY_REGISTER_READ, 8'h00);
        check(rd, 8'h60);
        // Corner bytes first, then random ones
        for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
            nv_write(d);
            a4 = d[1];
            check(interface_defaults_nonvolatile_out, d & 8'hee);
            check({7'h0, current_address_length_out}, {7'h0, d[1]});
            cmd(OP_ANY_REGISTER_READ, 8'h00);
            check(rd, d & 8'hee);
            pulse(1'b0, d & 8'hee);
            cmd(OP_ANY_REGISTER_READ, 8'h00);
            check(rd, d & 8'hee);
        end
        nv_write(8'h80);
        pulse(1'b1, 8'h80);
        host_u.frame({OP_ENTER_QUAD_INSTRUCTION}, 1'b0, rd);
        quad = 1;
        check({7'h0, quad_instruction_out}, 8'h01);
        cmd(OP_ANY_REGISTER_READ, 8'h00);
        check(rd, 8'h80);
        host_u.frame({OP_EXIT_QUAD_INSTRUCTION}, 1'b1, rd);
        quad = 0;
        check({7'h0, quad_instruction_out}, 8'h00);
        // Locked: both the program and the protocol switch are refused
        @(negedge clk_in);
        register_lock_bit_in = 1'b1;
        nv_write(8'h00);
        host_u.frame({OP_ENTER_QUAD_INSTRUCTION}, 1'b0, rd);
        check(interface_defaults_nonvolatile_out, 8'h80);
        check({7'h0, quad_instruction_out}, 8'h00);
        register_lock_bit_in = 1'b0;
        // Line 3 low while deselected acts as a reset
        host_u.set_line3(1'b0);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_in);
            d[0] = (i == 0) ? reset_request_out : (d[0] | reset_request_out);
        end
        check({7'h0, d[0]}, 8'h01);
        host_u.set_line3(1'b1);
        repeat (12) @(negedge clk_in);
        chk_ctl(8'h80);
        finish_test();
    end
endmodule
